// File: hdl/swc_defs.svh
// offsets, interruption codes and reset values of the status-word control
`ifndef SWC_DEFS_SVH
`define SWC_DEFS_SVH
// register offsets (byte addresses)
`define SWC_OFS_PSW_HI   4'h0
`define SWC_OFS_PSW_LO   4'h4
`define SWC_OFS_STATUS   4'h8
`define SWC_OFS_CTRL     4'hc
// reset value of the status word: supervisor, running, all masks shut
`define SWC_PSW_RST      64'h0000_0000_0000_0000
`define SWC_CTRL_RST     1'h0
// program interruption codes
`define SWC_CODE_PRIV    16'h0002
`define SWC_CODE_FPO     16'h0008
`define SWC_CODE_DECO    16'h000a
`define SWC_CODE_EXPU    16'h000d
`define SWC_CODE_SIGN    16'h000e
// external interruption code
`define SWC_CODE_EXT     16'h0040
// machine-check interruption code
`define SWC_CODE_MC      16'h0000
// decimal sign and zone codes
`define SWC_SIGN_STD_POS 4'hc
`define SWC_SIGN_STD_NEG 4'hd
`define SWC_SIGN_ALT_POS 4'ha
`define SWC_SIGN_ALT_NEG 4'hb
`define SWC_ZONE_STD     4'hf
`define SWC_ZONE_ALT     4'h5
`endif

// File: hdl/swc_pkg.sv
// types of the status-word control
package swc_pkg;
  // status word, bit 0 is the leftmost field
  typedef struct packed {
    logic [7:0]  sys_mask;  // bits 0-7
    logic [3:0]  key;       // bits 8-11
    logic        alt_code;  // bit 12
    logic        mc_mask;   // bit 13
    logic        wait_st;   // bit 14
    logic        problem;   // bit 15
    logic [15:0] icode;     // bits 16-31
    logic [1:0]  ilc;       // bits 32-33
    logic [1:0]  cc;        // bits 34-35
    logic [3:0]  pmask;     // bits 36-39
    logic [23:0] iaddr;     // bits 40-63
  } swc_psw_t;
  typedef enum logic [2:0] {
    SWC_OP_PLAIN, SWC_OP_SSM, SWC_OP_SPM, SWC_OP_LPSW,
    SWC_OP_IO, SWC_OP_PRIV, SWC_OP_SVC
  } swc_op_t;
  typedef struct packed {
    swc_op_t     op;
    logic [63:0] operand;
    logic [1:0]  cc;
    logic        cc_we;
    logic [23:0] next_ia;
  } swc_cmd_t;
  typedef enum logic [2:0] {
    SWC_IRQ_NONE, SWC_IRQ_MC, SWC_IRQ_PROG, SWC_IRQ_SVC,
    SWC_IRQ_EXT, SWC_IRQ_IO
  } swc_irq_t;
endpackage : swc_pkg

// File: hdl/swc_dec_codes.sv
// decimal sign and zone code generator
`timescale 1ns/1ps
`default_nettype none
module swc_dec_codes
  import swc_pkg::*;
(
  input  wire logic       clock_i,   // cpu clock
  input  wire logic       resetn_i,  // async reset, low
  input  wire logic       alt_i,     // character-code mode bit
  input  wire logic       neg_i,     // result is negative
  output logic      [3:0] sign_o,    // packed sign code
  output logic      [3:0] zone_o     // zone for unpacking
);
`include "swc_defs.svh"
  // registered so the decimal datapath sees a clean code
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sign_o <= `SWC_SIGN_STD_POS;
      zone_o <= `SWC_ZONE_STD;
    end else begin
      case ({alt_i, neg_i})
        2'b00:   sign_o <= `SWC_SIGN_STD_POS;
        2'b01:   sign_o <= `SWC_SIGN_STD_NEG;
        2'b10:   sign_o <= `SWC_SIGN_ALT_POS;
        default: sign_o <= `SWC_SIGN_ALT_NEG;
      endcase
      zone_o <= alt_i ? `SWC_ZONE_ALT : `SWC_ZONE_STD;
    end
  end
endmodule // swc_dec_codes
`default_nettype wire

// File: hdl/swc_core.sv
// status-word state control: masks, states, privilege and updates
`timescale 1ns/1ps
`default_nettype none
//
// Contract
// - four program-mask bits suppress four exceptions
// - other program exceptions always interrupt
// - supervisor call never masked
// - standard mode signs plus 1100 minus 1101
// - bit 12 set: signs 1010 and 1011
// - unpack zones follow character-code bit
// - wait bit stops instruction execution
// - only io or external ends wait
// - machine, program, svc only while running
// - bit 15 one means problem state
// - privileged in problem state raises exception
// - io instructions are privileged
// - load status word replaces all, privileged
// - whole word replaced only interruption or load
// - set system mask privileged, bits 0-7
// - set program mask writes bits 34-39
// - code by interruption, cc, address by execution
// - svc only way into supervisor state; core loads any fetched new word, so any interruption can clear bit 15
// - zero system mask bit blocks source
// - blocked io and external stay pending
// - program-mask zero blocks, one allows
module swc_core
  import swc_pkg::*;
#(
  parameter int NUM_CHAN = 7  // io channels under bits 0..6
)(
  input  wire logic        clock_i,        // cpu clock
  input  wire logic        resetn_i,       // async reset, low
  input  wire logic [3:0]  addr_i,         // register byte address
  input  wire logic [31:0] wdata_i,        // write data
  input  wire logic        wr_i,           // write strobe
  input  wire logic        rd_i,           // read strobe
  output logic      [31:0] rdata_o,        // read data, next cycle
  input  wire logic        exec_valid_i,   // instruction offered
  input  wire swc_cmd_t    exec_cmd_i,     // decoded instruction
  output logic             exec_ready_o,   // instruction taken
  input  wire logic        prog_exc_i,     // program exception pulse
  input  wire logic [15:0] prog_code_i,    // its code
  input  wire logic        mc_err_i,       // machine error pulse
  input  wire logic [NUM_CHAN-1:0] io_req_i, // io channel requests
  input  wire logic        ext_req_i,      // external request
  output logic             irq_take_o,     // interruption taken
  output swc_irq_t         irq_class_o,    // its class
  output swc_psw_t         old_psw_o,      // old word to store
  input  wire logic        new_psw_valid_i,// new word fetched
  input  wire swc_psw_t    new_psw_i,      // the new word
  output swc_psw_t         psw_o,          // current word
  output logic             halted_o,       // check stop
  input  wire logic        dec_neg_i,      // decimal result sign
  output logic      [3:0]  dec_sign_o,     // packed sign code
  output logic      [3:0]  dec_zone_o      // unpack zone
);
`include "swc_defs.svh"

  // elaboration check: only seven channel mask bits exist
  if (NUM_CHAN < 1 || NUM_CHAN > 7) begin : g_bad_chan
    $error("NUM_CHAN must be 1 to 7");
  end

  typedef enum logic {SWC_RUN, SWC_AWAIT} swc_state_t;

  swc_state_t       state_ff;
  swc_psw_t         psw_ff;
  logic [7:0]       pend_ff;
  logic             mc_ff;
  logic             stop_ff;
  logic             halted_ff;
  logic [7:0]       req;
  logic [7:0]       open_src;
  logic [7:0]       take_vec;
  logic [2:0]       take_idx;
  logic             running;
  logic             io_any;
  logic             mc_take;
  logic             prog_take;
  logic             maskable;
  logic             mask_ok;
  logic             accept;
  logic             priv_op;
  logic             fault;
  logic             svc;
  logic             any_take;
  swc_irq_t         nxt_class;
  logic [15:0]      nxt_code;

  // sources: bits 0..NUM_CHAN-1 channels, bit 7 external
  always_comb begin
    req = 8'h00;
    req[7] = ext_req_i;
    req[NUM_CHAN-1:0] = io_req_i;
  end

  // running means not awaiting the new word and not stopped; the wait bit is not part of it
  assign running = (state_ff == SWC_RUN) && !halted_ff;

  // zero mask bit blocks source
  // word bit 0 (field msb) guards channel 0, word bit 7 external
  for (genvar g = 0; g < 8; g++) begin : g_open
    assign open_src[g] = pend_ff[g] & psw_ff.sys_mask[7-g];
  end
  assign io_any = running && (open_src != 8'h00);

  // lowest numbered open source wins
  always_comb begin
    take_idx = 3'h7;
    for (int i = 7; i >= 0; i--) begin
      if (open_src[i])
        take_idx = 3'(i);
    end
  end

  always_comb begin
    case (prog_code_i)
      `SWC_CODE_FPO:  begin maskable = 1'b1; mask_ok = psw_ff.pmask[3]; end
      `SWC_CODE_DECO: begin maskable = 1'b1; mask_ok = psw_ff.pmask[2]; end
      `SWC_CODE_EXPU: begin maskable = 1'b1; mask_ok = psw_ff.pmask[1]; end
      `SWC_CODE_SIGN: begin maskable = 1'b1; mask_ok = psw_ff.pmask[0]; end
      default:        begin maskable = 1'b0; mask_ok = 1'b1; end
    endcase
  end

  // no machine or program interruption while waiting
  assign mc_take = running && !psw_ff.wait_st && mc_ff && psw_ff.mc_mask;
  assign prog_take = running && !psw_ff.wait_st && prog_exc_i && mask_ok;

  // interruptions have priority over the next instruction
  // wait bit blocks execution
  assign exec_ready_o = running && !psw_ff.wait_st && !mc_take
                        && !prog_take && !io_any;
  assign accept = exec_valid_i && exec_ready_o;

  assign priv_op = (exec_cmd_i.op == SWC_OP_SSM)
                || (exec_cmd_i.op == SWC_OP_LPSW)
                || (exec_cmd_i.op == SWC_OP_IO)
                || (exec_cmd_i.op == SWC_OP_PRIV);
  assign fault = accept && priv_op && psw_ff.problem;
  assign svc = accept && (exec_cmd_i.op == SWC_OP_SVC);

  assign any_take = mc_take || prog_take || io_any || fault || svc;

  // class and code of the interruption taken this cycle
  always_comb begin
    nxt_class = SWC_IRQ_NONE;
    nxt_code = 16'h0000;
    if (mc_take) begin
      nxt_class = SWC_IRQ_MC;
      nxt_code = `SWC_CODE_MC;
    end else if (prog_take) begin
      nxt_class = SWC_IRQ_PROG;
      nxt_code = prog_code_i;
    end else if (io_any) begin
      // only io or external out of wait
      nxt_class = (take_idx == 3'h7) ? SWC_IRQ_EXT : SWC_IRQ_IO;
      nxt_code = (take_idx == 3'h7) ? `SWC_CODE_EXT
                                    : {13'h0000, take_idx};
    end else if (fault) begin
      nxt_class = SWC_IRQ_PROG;
      nxt_code = `SWC_CODE_PRIV;
    end else if (svc) begin
      nxt_class = SWC_IRQ_SVC;
      nxt_code = {8'h00, exec_cmd_i.operand[7:0]};
    end
  end

  // sequencing between running and fetching the new word
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i)
      state_ff <= SWC_RUN;
    else if (state_ff == SWC_RUN && any_take)
      state_ff <= SWC_AWAIT;
    else if (state_ff == SWC_AWAIT && new_psw_valid_i)
      state_ff <= SWC_RUN;
  end

  // the status word itself
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      psw_ff <= `SWC_PSW_RST;
    end else if (state_ff == SWC_AWAIT) begin
      if (new_psw_valid_i)
        psw_ff <= new_psw_i;
    end else if (accept && !fault && !svc) begin
      psw_ff.iaddr <= exec_cmd_i.next_ia;
      if (exec_cmd_i.cc_we)
        psw_ff.cc <= exec_cmd_i.cc;
      case (exec_cmd_i.op)
        SWC_OP_SSM: psw_ff.sys_mask <= exec_cmd_i.operand[7:0];
        SWC_OP_SPM: {psw_ff.cc, psw_ff.pmask} <= exec_cmd_i.operand[29:24];
        SWC_OP_LPSW: psw_ff <= swc_psw_t'(exec_cmd_i.operand);
        default: ;
      endcase
    end
  end

  // old word: current word, code filled, address past the instruction
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      old_psw_o <= `SWC_PSW_RST;
      irq_take_o <= 1'b0;
      irq_class_o <= SWC_IRQ_NONE;
    end else begin
      irq_take_o <= (state_ff == SWC_RUN) && any_take;
      if ((state_ff == SWC_RUN) && any_take) begin
        irq_class_o <= nxt_class;
        old_psw_o <= psw_ff;
        old_psw_o.icode <= nxt_code;
        if (fault || svc)
          old_psw_o.iaddr <= exec_cmd_i.next_ia;
      end
    end
  end

  // pending until taken; a new request beats the clear
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i)
      pend_ff <= 8'h00;
    else
      pend_ff <= (pend_ff & ~take_vec) | req;
  end
  assign take_vec = (state_ff == SWC_RUN && io_any && !mc_take
                     && !prog_take) ? (8'h01 << take_idx) : 8'h00;

  // machine check: taken, ignored when masked, or a check stop
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mc_ff <= 1'b0;
      halted_ff <= 1'b0;
    end else begin
      if (mc_err_i && stop_ff)
        halted_ff <= 1'b1;
      else if (!stop_ff)
        halted_ff <= 1'b0;
      if (mc_err_i)
        mc_ff <= !stop_ff;
      else if (mc_take || !psw_ff.mc_mask)
        mc_ff <= 1'b0;
    end
  end
  assign halted_o = halted_ff;
  assign psw_o = psw_ff;

  // control register: check-stop select
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i)
      stop_ff <= `SWC_CTRL_RST;
    else if (wr_i && addr_i == `SWC_OFS_CTRL)
      stop_ff <= wdata_i[0];
  end

  // read port; the word itself is read-only on this bus
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o <= 32'h0000_0000;
    end else if (rd_i) begin
      case (addr_i)
        `SWC_OFS_PSW_HI: rdata_o <= psw_ff[63:32];
        `SWC_OFS_PSW_LO: rdata_o <= psw_ff[31:0];
        `SWC_OFS_STATUS: rdata_o <= {20'h00000, halted_ff,
                                     state_ff == SWC_AWAIT, mc_ff,
                                     psw_ff.wait_st, pend_ff};
        `SWC_OFS_CTRL:   rdata_o <= {31'h0000_0000, stop_ff};
        default:         rdata_o <= 32'h0000_0000;
      endcase
    end else begin
      rdata_o <= 32'h0000_0000;
    end
  end

  // decimal sign and zone codes from bit 12
  swc_dec_codes u_dec (
    .clock_i  (clock_i),
    .resetn_i (resetn_i),
    .alt_i    (psw_ff.alt_code),
    .neg_i    (dec_neg_i),
    .sign_o   (dec_sign_o),
    .zone_o   (dec_zone_o)
  );

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);

  sequence s_svc;
    accept && exec_cmd_i.op == SWC_OP_SVC;
  endsequence
  sequence s_priv_fault;
    accept && priv_op && psw_ff.problem;
  endsequence

  prog_masked_a: assert property (
    prog_exc_i && maskable && !mask_ok && !mc_take && !io_any
    && !exec_valid_i |=> !irq_take_o)
    else $error("masked program exception interrupted");
  prog_unmask_a: assert property (
    running && !psw_ff.wait_st && prog_exc_i && !maskable && !mc_take
    |=> irq_take_o && irq_class_o == SWC_IRQ_PROG
        && old_psw_o.icode == $past(prog_code_i))
    else $error("unmaskable exception lost");
  svc_take_a: assert property (
    s_svc |=> irq_take_o && irq_class_o == SWC_IRQ_SVC
              ##1 state_ff == SWC_AWAIT)
    else $error("supervisor call not taken");
  wait_hold_a: assert property (
    psw_ff.wait_st |-> !exec_ready_o)
    else $error("instruction taken in wait");
  wait_exit_a: assert property (
    psw_ff.wait_st && state_ff == SWC_RUN ##1 irq_take_o
    |-> irq_class_o == SWC_IRQ_IO || irq_class_o == SWC_IRQ_EXT)
    else $error("wait ended by wrong class");
  priv_fault_a: assert property (
    s_priv_fault |=> irq_take_o && old_psw_o.icode == `SWC_CODE_PRIV
                     && psw_ff == $past(psw_ff))
    else $error("privileged op not refused");
  ssm_only_a: assert property (
    accept && exec_cmd_i.op == SWC_OP_SSM && !psw_ff.problem
    && !exec_cmd_i.cc_we |=> psw_ff.sys_mask == $past(exec_cmd_i.operand[7:0])
        && psw_ff[55:24] == $past(psw_ff[55:24]))
    else $error("set system mask touched other bits");
  spm_bits_a: assert property (
    accept && exec_cmd_i.op == SWC_OP_SPM
    |=> {psw_ff.cc, psw_ff.pmask} == $past(exec_cmd_i.operand[29:24])
        && psw_ff[63:30] == $past(psw_ff[63:30]))
    else $error("set program mask wrong");
  await_hold_a: assert property (
    state_ff == SWC_AWAIT && !new_psw_valid_i |=> $stable(psw_ff))
    else $error("word changed while awaiting new word");
  pend_keep_a: assert property (
    pend_ff[7] && !psw_ff.sys_mask[0] |=> pend_ff[7])
    else $error("blocked external request lost");

endmodule // swc_core
`default_nettype wire

// File: dv/tb.sv
// self-checking bench of the status-word control
`timescale 1ns/1ps
`default_nettype none
`include "swc_defs.svh"
module tb;
  import swc_pkg::*;
  logic        clock_i, resetn_i, wr_i, rd_i, exec_valid_i, exec_ready_o;
  logic        prog_exc_i, mc_err_i, ext_req_i, irq_take_o, halted_o;
  logic        new_psw_valid_i, dec_neg_i;
  logic [3:0]  addr_i, dec_sign_o, dec_zone_o;
  logic [31:0] wdata_i, rdata_o;
  logic [15:0] prog_code_i;
  logic [6:0]  io_req_i;
  swc_cmd_t    exec_cmd_i;
  swc_irq_t    irq_class_o;
  swc_psw_t    old_psw_o, new_psw_i, psw_o;
  int          failures, checks;

  swc_core swc_core_inst (.clock_i(clock_i), .resetn_i(resetn_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .exec_valid_i(exec_valid_i),
    .exec_cmd_i(exec_cmd_i), .exec_ready_o(exec_ready_o),
    .prog_exc_i(prog_exc_i), .prog_code_i(prog_code_i),
    .mc_err_i(mc_err_i), .io_req_i(io_req_i), .ext_req_i(ext_req_i),
    .irq_take_o(irq_take_o), .irq_class_o(irq_class_o),
    .old_psw_o(old_psw_o), .new_psw_valid_i(new_psw_valid_i),
    .new_psw_i(new_psw_i), .psw_o(psw_o), .halted_o(halted_o),
    .dec_neg_i(dec_neg_i), .dec_sign_o(dec_sign_o),
    .dec_zone_o(dec_zone_o));

  // free-running 20 MHz clock
  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end

  task automatic wrap_up();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, exp, input string what);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // every wait is bounded, a stuck design ends the run
  task automatic timeout(input string what);
    failures++;
    $display("mismatch at %0t: no answer to %s", $time, what);
    wrap_up();
  endtask

  function automatic swc_psw_t mk(logic [7:0] sm, logic al, wt, pr,
                                  logic [3:0] pm);
    swc_psw_t p;
    p = '0;
    p.sys_mask = sm;
    p.alt_code = al;
    p.wait_st = wt;
    p.problem = pr;
    p.pmask = pm;
    p.iaddr = 24'h000100;
    return p;
  endfunction

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    @(negedge clock_i);
    chk(rdata_o, e, "rdata");
  endtask

  // offer an instruction, hold it until the ready edge
  task automatic exec(input swc_op_t op, input logic [63:0] opnd,
                      input logic we);
    int n;
    n = 0;
    @(posedge clock_i);
    exec_cmd_i <= '{op, opnd, 2'b01, we, 24'h000200};
    exec_valid_i <= 1'b1;
    @(negedge clock_i);
    while (exec_ready_o !== 1'b1 && n < 50) begin
      @(negedge clock_i);
      n++;
    end
    if (n >= 50) timeout("exec");
    @(posedge clock_i);
    exec_valid_i <= 1'b0;
  endtask

  task automatic lpsw(input swc_psw_t p);
    exec(SWC_OP_LPSW, p, 1'b0);
    @(negedge clock_i);
    chk(psw_o, p, "loaded word");
  endtask

  // wait for a take, check it, then hand over the new word
  task automatic take(input swc_irq_t c, input logic [15:0] code,
                      input swc_psw_t np);
    int n;
    n = 0;
    @(negedge clock_i);
    while (irq_take_o !== 1'b1 && n < 50) begin
      @(negedge clock_i);
      n++;
    end
    if (n >= 50) timeout("interruption");
    chk(irq_class_o, c, "class");
    chk(old_psw_o.icode, code, "code");
    @(posedge clock_i);
    new_psw_i <= np;
    new_psw_valid_i <= 1'b1;
    @(posedge clock_i);
    new_psw_valid_i <= 1'b0;
    @(negedge clock_i);
    chk(psw_o, np, "new word");
  endtask

  task automatic no_take();
    repeat (4) begin
      @(negedge clock_i);
      chk(irq_take_o, 1'b0, "unwanted take");
    end
  endtask

  task automatic prog(input logic [15:0] code);
    @(posedge clock_i);
    prog_code_i <= code;
    prog_exc_i <= 1'b1;
    @(posedge clock_i);
    prog_exc_i <= 1'b0;
  endtask

  task automatic t_reset();
    rd(`SWC_OFS_PSW_HI, 32'h0000_0000);
    rd(`SWC_OFS_PSW_LO, 32'h0000_0000);
    rd(4'h2, 32'h0000_0000);
    wr(`SWC_OFS_PSW_HI, 32'hffff_ffff);
    rd(`SWC_OFS_PSW_HI, 32'h0000_0000);
    wr(`SWC_OFS_CTRL, 32'h0000_0001);
    rd(`SWC_OFS_CTRL, 32'h0000_0001);
    // a machine error under check-stop halts the processor
    @(posedge clock_i);
    mc_err_i <= 1'b1;
    @(posedge clock_i);
    mc_err_i <= 1'b0;
    @(negedge clock_i);
    chk(halted_o, 1'b1, "check stop");
    chk(exec_ready_o, 1'b0, "ready while halted");
    rd(`SWC_OFS_STATUS, 32'h0000_0800);
    wr(`SWC_OFS_CTRL, 32'h0000_0000);
    rd(`SWC_OFS_STATUS, 32'h0000_0000);
    chk(halted_o, 1'b0, "halt released");
    chk(exec_ready_o, 1'b1, "ready after reset");
    $display("test reset done");
  endtask

  task automatic t_masks();
    logic [15:0] codes [4];
    swc_psw_t    m;
    codes = '{`SWC_CODE_FPO, `SWC_CODE_DECO, `SWC_CODE_EXPU, `SWC_CODE_SIGN};
    prog(codes[0]);
    no_take();
    // each mask bit opens its own exception and not the next one
    for (int i = 0; i < 4; i++) begin
      lpsw(mk(8'h00, 1'b0, 1'b0, 1'b0, 4'h8 >> i));
      prog(codes[i]);
      take(SWC_IRQ_PROG, codes[i], mk(8'h00, 1'b0, 1'b0, 1'b0, 4'h0));
      lpsw(mk(8'h00, 1'b0, 1'b0, 1'b0, 4'h8 >> i));
      prog(codes[(i + 1) % 4]);
      no_take();
    end
    prog(16'h0006);
    take(SWC_IRQ_PROG, 16'h0006, mk(8'h00, 1'b0, 1'b0, 1'b0, 4'h0));
    m = mk(8'h00, 1'b0, 1'b0, 1'b0, 4'h0);
    m.mc_mask = 1'b1;
    lpsw(m);
    @(posedge clock_i);
    mc_err_i <= 1'b1;
    @(posedge clock_i);
    mc_err_i <= 1'b0;
    take(SWC_IRQ_MC, `SWC_CODE_MC, mk(8'h00, 1'b0, 1'b0, 1'b0, 4'h0));
    $display("test masks done");
  endtask

  task automatic t_priv();
    swc_op_t  ops [4];
    swc_psw_t pp, e;
    ops = '{SWC_OP_SSM, SWC_OP_LPSW, SWC_OP_IO, SWC_OP_PRIV};
    pp = mk(8'h00, 1'b0, 1'b0, 1'b1, 4'h0);
    lpsw(pp);
    foreach (ops[i]) begin
      exec(ops[i], 64'h0000_0000_0000_00ff, 1'b0);
      take(SWC_IRQ_PROG, `SWC_CODE_PRIV, pp);
      chk(old_psw_o.sys_mask, 8'h00, "faulted op changed mask");
    end
    exec(SWC_OP_SPM, 64'h0000_0000_2a00_0000, 1'b0);
    e = pp;
    e.cc = 2'b10;
    e.pmask = 4'b1010;
    e.iaddr = 24'h000200;
    @(negedge clock_i);
    chk(psw_o, e, "spm");
    exec(SWC_OP_PLAIN, 64'h0, 1'b1);
    e.cc = 2'b01;
    e.iaddr = 24'h000200;
    @(negedge clock_i);
    chk(psw_o, e, "plain");
    exec(SWC_OP_SVC, 64'h0000_0000_0000_005a, 1'b0);
    take(SWC_IRQ_SVC, 16'h005a, mk(8'h00, 1'b0, 1'b0, 1'b0, 4'h0));
    chk(old_psw_o.problem, 1'b1, "svc old state");
    $display("test privilege done");
  endtask

  task automatic t_ext();
    @(posedge clock_i);
    ext_req_i <= 1'b1;
    @(posedge clock_i);
    ext_req_i <= 1'b0;
    no_take();
    rd(`SWC_OFS_STATUS, 32'h0000_0080);
    exec(SWC_OP_SSM, 64'h0000_0000_0000_0001, 1'b0);
    take(SWC_IRQ_EXT, `SWC_CODE_EXT, mk(8'h00, 1'b0, 1'b0, 1'b0, 4'h0));
    chk(old_psw_o.sys_mask, 8'h01, "ssm mask");
    $display("test external done");
  endtask

  task automatic t_dec();
    logic [3:0] sgn [4];
    sgn = '{4'hc, 4'hd, 4'ha, 4'hb};
    for (int i = 0; i < 4; i++) begin
      if (i % 2 == 0) lpsw(mk(8'h00, i > 1, 1'b0, 1'b0, 4'h0));
      @(posedge clock_i);
      dec_neg_i <= 1'(i % 2);
      repeat (2) @(negedge clock_i);
      chk(dec_sign_o, sgn[i], "sign");
      chk(dec_zone_o, i > 1 ? `SWC_ZONE_ALT : `SWC_ZONE_STD, "zone");
    end
    $display("test decimal done");
  endtask

  task automatic t_wait();
    lpsw(mk(8'h80, 1'b0, 1'b1, 1'b0, 4'hf));
    chk(exec_ready_o, 1'b0, "ready in wait");
    prog(16'h0006);
    no_take();
    @(posedge clock_i);
    io_req_i <= 7'h02;
    @(posedge clock_i);
    io_req_i <= 7'h00;
    no_take();
    rd(`SWC_OFS_STATUS, 32'h0000_0102);
    @(posedge clock_i);
    io_req_i <= 7'h01;
    @(posedge clock_i);
    io_req_i <= 7'h00;
    take(SWC_IRQ_IO, 16'h0000, mk(8'h00, 1'b0, 1'b0, 1'b0, 4'h0));
    chk(exec_ready_o, 1'b1, "ready after wait");
    $display("test wait done");
  endtask

  // reset for five cycles, then the scenarios in turn
  initial begin
    resetn_i = 1'b0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 4'h0;
    wdata_i = 32'h0;
    exec_valid_i = 1'b0;
    exec_cmd_i = '0;
    prog_exc_i = 1'b0;
    prog_code_i = 16'h0;
    mc_err_i = 1'b0;
    io_req_i = 7'h00;
    ext_req_i = 1'b0;
    new_psw_valid_i = 1'b0;
    new_psw_i = '0;
    dec_neg_i = 1'b0;
    failures = 0;
    checks = 0;
    repeat (5) @(posedge clock_i);
    resetn_i <= 1'b1;
    t_reset();
    t_masks();
    t_priv();
    t_ext();
    t_dec();
    t_wait();
    wrap_up();
  end
endmodule // tb
`default_nettype wire
